// ===== src/bia_regs.vh
// Constants for the binary integer arithmetic unit
// How it works
// RL1: zero_flag set when sized result is zero
// RL2: 8, 16, 32 bit widths; flags at width
// RL3: carry_flag is carry on add, borrow on subtract
// RL4: sign_flag copies sized result sign bit
// RL5: add overflow: carry into sign, none out
// RL6: subtract overflow: below most negative value
// RL7: sum_op writes dst plus src, six flags
// RL8: sum_with_carry_op also adds carry_flag
// RL9: plus_one_op adds one, carry_flag kept
// RL10: difference_op writes dst minus src, six flags
// RL11: difference_with_borrow_op also subtracts carry_flag
// RL12: minus_one_op subtracts one, carry_flag kept
// RL13: compare_only_op sets flags, writes nothing back
// RL14: sign_flip_op writes zero minus operand
// RL15: unsigned_product_op: acc times src, double length
// RL16: unsigned product: carry/overflow when upper nonzero
// RL17: signed one-operand form uses accumulator pair
// RL18: signed two-operand form writes general register
// RL19: signed three-operand form, byte immediate sign-extended
// RL20: signed product flags: upper not sign extension
// RL21: two/three-operand forms store truncated low half
// RL22: never both source and destination in memory
// RL23: aux carry at bit 3; parity of low byte
`ifndef BIA_REGS_VH
`define BIA_REGS_VH

// ----------------------------------------
// Operation codes
// ----------------------------------------
`define BIA_OP_ADD 4'h0
`define BIA_OP_ADC 4'h1
`define BIA_OP_INC 4'h2
`define BIA_OP_SUB 4'h3
`define BIA_OP_SBB 4'h4
`define BIA_OP_DEC 4'h5
`define BIA_OP_CMP 4'h6
`define BIA_OP_NEG 4'h7
`define BIA_OP_MUL 4'h8
`define BIA_OP_SIGNED_PRODUCT_OP 4'h9

// ----------------------------------------
// Operand sizes and product forms
// ----------------------------------------
`define BIA_SZ_BYTE 2'h0
`define BIA_SZ_WORD 2'h1
`define BIA_SZ_DWORD 2'h2
`define BIA_FORM_ONE 2'h0
`define BIA_FORM_TWO 2'h1
`define BIA_FORM_THREE 2'h2

// ----------------------------------------
// Bit positions and reset values
// ----------------------------------------
`define BIA_SIGN_B 7
`define BIA_SIGN_W 15
`define BIA_SIGN_D 31
`define BIA_AUX_BIT 4
`define BIA_FLAGS_RST 6'h00
`define BIA_IDX_CF 0
`define BIA_IDX_PF 1
`define BIA_IDX_AF 2
`define BIA_IDX_ZF 3
`define BIA_IDX_SF 4
`define BIA_IDX_OF 5

`endif

// ===== src/bia_addsub.v
// Sized adder and subtractor with carry, overflow and aux carry
`timescale 1ns/1ps
`include "bia_regs.vh"
module bia_addsub
(
    // Operands
    input wire [31:0] a_i,
    input wire [31:0] b_i,
    input wire cin_i,
    input wire sub_i,
    input wire [1:0] size_i,
    // Results
    output reg [31:0] res_o,
    output reg cout_o,
    output reg ovf_o,
    output reg aux_o
);
    reg [31:0] mask;
    reg [32:0] am;
    reg [32:0] bm;
    reg [32:0] s;
    reg sa;
    reg sb;
    reg sr;

    always @*
    begin
        case (size_i)
            `BIA_SZ_BYTE: mask = 32'h0000_00ff;
            `BIA_SZ_WORD: mask = 32'h0000_ffff;
            default: mask = 32'hffff_ffff;
        endcase
        // Zero-extended operands make bit w the carry or borrow
        am = {1'b0, a_i & mask};
        bm = {1'b0, b_i & mask};
        if (sub_i)
            s = am - bm - {32'h0000_0000, cin_i};
        else
            s = am + bm + {32'h0000_0000, cin_i};
        res_o = s[31:0] & mask;
        case (size_i)
            `BIA_SZ_BYTE:
            begin
                cout_o = s[`BIA_SIGN_B + 1]; // RL2 RL3
                sa = am[`BIA_SIGN_B];
                sb = bm[`BIA_SIGN_B];
                sr = s[`BIA_SIGN_B];
            end
            `BIA_SZ_WORD:
            begin
                cout_o = s[`BIA_SIGN_W + 1]; // RL2 RL3
                sa = am[`BIA_SIGN_W];
                sb = bm[`BIA_SIGN_W];
                sr = s[`BIA_SIGN_W];
            end
            default:
            begin
                cout_o = s[`BIA_SIGN_D + 1]; // RL2 RL3
                sa = am[`BIA_SIGN_D];
                sb = bm[`BIA_SIGN_D];
                sr = s[`BIA_SIGN_D];
            end
        endcase
        // Same as carry into sign xor carry out of sign
        if (sub_i)
            ovf_o = (sa != sb) && (sr != sa); // RL6
        else
            ovf_o = (sa == sb) && (sr != sa); // RL5
        aux_o = am[`BIA_AUX_BIT] ^ bm[`BIA_AUX_BIT] ^ s[`BIA_AUX_BIT]; // RL23
    end
endmodule // bia_addsub

// ===== src/bia_mul.v
// Sized signed or unsigned multiplier with double-length product
`timescale 1ns/1ps
`include "bia_regs.vh"
module bia_mul
(
    // Operands
    input wire [31:0] a_i,
    input wire [31:0] b_i,
    input wire signed_i,
    input wire [1:0] size_i,
    // Product halves, each in low bits
    output reg [31:0] lo_o,
    output reg [31:0] hi_o,
    output reg wide_o
);
    reg [63:0] ax;
    reg [63:0] bx;
    reg [63:0] p;
    reg [31:0] ext;

    always @*
    begin
        // Two's complement low 64 bits serve both signednesses
        case (size_i)
            `BIA_SZ_BYTE:
            begin
                ax = {{56{signed_i & a_i[`BIA_SIGN_B]}}, a_i[7:0]};
                bx = {{56{signed_i & b_i[`BIA_SIGN_B]}}, b_i[7:0]};
            end
            `BIA_SZ_WORD:
            begin
                ax = {{48{signed_i & a_i[`BIA_SIGN_W]}}, a_i[15:0]};
                bx = {{48{signed_i & b_i[`BIA_SIGN_W]}}, b_i[15:0]};
            end
            default:
            begin
                ax = {{32{signed_i & a_i[`BIA_SIGN_D]}}, a_i};
                bx = {{32{signed_i & b_i[`BIA_SIGN_D]}}, b_i};
            end
        endcase
        p = ax * bx;
        case (size_i)
            `BIA_SZ_BYTE:
            begin
                lo_o = {24'h000000, p[7:0]};
                hi_o = {24'h000000, p[15:8]};
                ext = {24'h000000, {8{signed_i & p[`BIA_SIGN_B]}}};
            end
            `BIA_SZ_WORD:
            begin
                lo_o = {16'h0000, p[15:0]};
                hi_o = {16'h0000, p[31:16]};
                ext = {16'h0000, {16{signed_i & p[`BIA_SIGN_W]}}};
            end
            default:
            begin
                lo_o = p[31:0];
                hi_o = p[63:32];
                ext = {32{signed_i & p[`BIA_SIGN_D]}};
            end
        endcase
        // Unsigned: upper nonzero; signed: upper not sign extension
        wide_o = (hi_o != ext); // RL16 RL20
    end
endmodule // bia_mul

// ===== src/bia_alu.v
// Binary integer arithmetic unit with status flag register
`timescale 1ns/1ps
`include "bia_regs.vh"
module bia_alu
(
    // Clock and reset
    input wire clk_i,
    input wire rst_b_i,
    // Request from decode
    input wire start_i,
    input wire [3:0] op_i,
    input wire [1:0] size_i,
    input wire [1:0] form_i,
    input wire src_mem_i,
    input wire dst_mem_i,
    // Operands
    input wire [31:0] dst_i,
    input wire [31:0] src_i,
    input wire [31:0] acc_i,
    input wire [31:0] imm_i,
    input wire imm_byte_i,
    // Flag restore from the core
    input wire flags_load_i,
    input wire [5:0] flags_i,
    // Results
    output reg [31:0] result_o,
    output reg [31:0] result_hi_o,
    output reg write_o,
    output reg write_hi_o,
    output reg done_o,
    output reg illegal_o,
    // Status flags
    output wire carry_flag_o,
    output wire parity_flag_o,
    output wire aux_carry_flag_o,
    output wire zero_flag_o,
    output wire sign_flag_o,
    output wire overflow_flag_o
);

    // ----------------------------------------
    // Flag register
    // ----------------------------------------
    reg [5:0] flags_q;
    reg [5:0] flags_d;

    assign carry_flag_o = flags_q[`BIA_IDX_CF];
    assign parity_flag_o = flags_q[`BIA_IDX_PF];
    assign aux_carry_flag_o = flags_q[`BIA_IDX_AF];
    assign zero_flag_o = flags_q[`BIA_IDX_ZF];
    assign sign_flag_o = flags_q[`BIA_IDX_SF];
    assign overflow_flag_o = flags_q[`BIA_IDX_OF];

    // ----------------------------------------
    // Operation decode
    // ----------------------------------------
    reg is_add;
    reg is_sub;
    reg is_mul;
    reg keep_cf;
    reg no_write;
    reg bad_req;

    always @*
    begin
        is_add = 1'b0;
        is_sub = 1'b0;
        is_mul = 1'b0;
        keep_cf = 1'b0;
        no_write = 1'b0;
        case (op_i)
            `BIA_OP_ADD: is_add = 1'b1;
            `BIA_OP_ADC: is_add = 1'b1;
            `BIA_OP_INC:
            begin
                is_add = 1'b1;
                keep_cf = 1'b1; // RL9
            end
            `BIA_OP_SUB: is_sub = 1'b1;
            `BIA_OP_SBB: is_sub = 1'b1;
            `BIA_OP_DEC:
            begin
                is_sub = 1'b1;
                keep_cf = 1'b1; // RL12
            end
            `BIA_OP_CMP:
            begin
                is_sub = 1'b1;
                no_write = 1'b1; // RL13
            end
            `BIA_OP_NEG: is_sub = 1'b1;
            `BIA_OP_MUL: is_mul = 1'b1;
            `BIA_OP_SIGNED_PRODUCT_OP: is_mul = 1'b1;
            default: is_add = 1'b0;
        endcase
        // Unknown codes and sizes are refused as well as memory pairs
        bad_req = (src_mem_i & dst_mem_i) // RL22
            | ~(is_add | is_sub | is_mul)
            | (size_i > `BIA_SZ_DWORD)
            | ((op_i == `BIA_OP_SIGNED_PRODUCT_OP) & (form_i > `BIA_FORM_THREE));
    end

    // ----------------------------------------
    // Adder operand selection
    // ----------------------------------------
    reg [31:0] as_a;
    reg [31:0] as_b;
    reg as_cin;

    always @*
    begin
        as_a = dst_i;
        as_b = src_i;
        as_cin = 1'b0;
        case (op_i)
            `BIA_OP_ADC: as_cin = flags_q[`BIA_IDX_CF]; // RL8
            `BIA_OP_SBB: as_cin = flags_q[`BIA_IDX_CF]; // RL11
            `BIA_OP_INC: as_b = 32'h0000_0001; // RL9
            `BIA_OP_DEC: as_b = 32'h0000_0001; // RL12
            `BIA_OP_NEG:
            begin
                as_a = 32'h0000_0000; // RL14
                as_b = dst_i;
            end
            default: as_cin = 1'b0;
        endcase
    end

    wire [31:0] as_res;
    wire as_cout;
    wire as_ovf;
    wire as_aux;

    bia_addsub u_addsub
    (
        .a_i(as_a),
        .b_i(as_b),
        .cin_i(as_cin),
        .sub_i(is_sub),
        .size_i(size_i),
        .res_o(as_res),
        .cout_o(as_cout),
        .ovf_o(as_ovf),
        .aux_o(as_aux)
    );

    // ----------------------------------------
    // Multiplier operand selection
    // ----------------------------------------
    reg [31:0] mu_a;
    reg [31:0] mu_b;
    reg one_form;

    always @*
    begin
        mu_a = acc_i;
        mu_b = src_i;
        one_form = 1'b1;
        if (op_i == `BIA_OP_SIGNED_PRODUCT_OP)
        begin
            case (form_i)
                `BIA_FORM_TWO:
                begin
                    mu_a = dst_i; // RL18
                    one_form = 1'b0;
                end
                `BIA_FORM_THREE:
                begin
                    // Byte immediate widened before the multiply
                    if (imm_byte_i)
                        mu_a = {{24{imm_i[`BIA_SIGN_B]}}, imm_i[7:0]}; // RL19
                    else
                        mu_a = imm_i;
                    one_form = 1'b0;
                end
                default: mu_a = acc_i; // RL17
            endcase
        end
    end

    wire [31:0] mu_lo;
    wire [31:0] mu_hi;
    wire mu_wide;

    bia_mul u_mul
    (
        .a_i(mu_a),
        .b_i(mu_b),
        .signed_i(op_i == `BIA_OP_SIGNED_PRODUCT_OP),
        .size_i(size_i),
        .lo_o(mu_lo),
        .hi_o(mu_hi),
        .wide_o(mu_wide)
    );

    // ----------------------------------------
    // Sized status of the adder result
    // ----------------------------------------
    reg res_sign;
    reg res_zero;
    wire res_par;

    // Zero judged on the sized bits only, not on upstream masking
    always @*
    begin
        case (size_i)
            `BIA_SZ_BYTE:
            begin
                res_sign = as_res[`BIA_SIGN_B]; // RL4
                res_zero = (as_res[`BIA_SIGN_B:0] == 8'h00); // RL1 RL2
            end
            `BIA_SZ_WORD:
            begin
                res_sign = as_res[`BIA_SIGN_W]; // RL4
                res_zero = (as_res[`BIA_SIGN_W:0] == 16'h0000); // RL1 RL2
            end
            default:
            begin
                res_sign = as_res[`BIA_SIGN_D]; // RL4
                res_zero = (as_res == 32'h0000_0000); // RL1 RL2
            end
        endcase
    end

    // Even count of ones in the low byte
    assign res_par = ~(^as_res[7:0]); // RL23

    // ----------------------------------------
    // Request acceptance
    // ----------------------------------------
    wire take;
    wire refuse;

    // A refused request still blocks a flag restore in its cycle
    assign take = start_i & ~bad_req;
    assign refuse = start_i & bad_req; // RL22

    // ----------------------------------------
    // Flag next state
    // ----------------------------------------
    always @*
    begin
        flags_d = flags_q;
        if (take)
        begin
            if (is_mul)
            begin
                // Other four flags are undefined; they are left as they were
                flags_d[`BIA_IDX_CF] = mu_wide; // RL16 RL20
                flags_d[`BIA_IDX_OF] = mu_wide; // RL16 RL20
            end
            else
            begin
                // Six flags from one sized result; five for plus one and minus one, which keep carry
                flags_d[`BIA_IDX_ZF] = res_zero; // RL1 RL7 RL10
                flags_d[`BIA_IDX_SF] = res_sign; // RL4
                flags_d[`BIA_IDX_OF] = as_ovf; // RL5 RL6
                flags_d[`BIA_IDX_AF] = as_aux; // RL23
                flags_d[`BIA_IDX_PF] = res_par; // RL23
                if (!keep_cf)
                    flags_d[`BIA_IDX_CF] = as_cout; // RL3 RL10
            end
        end
        else if (flags_load_i && !start_i)
        begin
            // Restore only when no request at all arrives this cycle
            flags_d = flags_i;
        end
    end

    // ----------------------------------------
    // Result next state
    // ----------------------------------------
    reg [31:0] result_d;
    reg [31:0] result_hi_d;
    reg write_d;
    reg write_hi_d;

    always @*
    begin
        result_d = result_o;
        result_hi_d = result_hi_o;
        write_d = 1'b0;
        write_hi_d = 1'b0;
        if (take && is_mul)
        begin
            result_d = mu_lo; // RL21
            result_hi_d = mu_hi; // RL15 RL17
            write_d = 1'b1;
            write_hi_d = one_form; // RL15
        end
        else if (take && !no_write)
        begin
            result_d = as_res; // RL7 RL10 RL14
            write_d = 1'b1;
        end
    end

    // ----------------------------------------
    // Flag flip-flops
    // ----------------------------------------
    always @(posedge clk_i)
    begin
        if (!rst_b_i)
            flags_q <= `BIA_FLAGS_RST;
        else
            flags_q <= flags_d;
    end

    // ----------------------------------------
    // Result registers
    // ----------------------------------------
    always @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            result_o <= 32'h0000_0000;
            result_hi_o <= 32'h0000_0000;
        end
        else
        begin
            result_o <= result_d;
            result_hi_o <= result_hi_d;
        end
    end

    // ----------------------------------------
    // Strobes, one cycle after the request
    // ----------------------------------------
    always @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            write_o <= 1'b0;
            write_hi_o <= 1'b0;
            done_o <= 1'b0;
            illegal_o <= 1'b0;
        end
        else
        begin
            write_o <= write_d;
            write_hi_o <= write_hi_d;
            done_o <= start_i;
            illegal_o <= refuse; // RL22
        end
    end

endmodule // bia_alu

// ===== tb/bia_rf_mdl.sv
// Write-back register model of the core beside the unit
`timescale 1ns/1ps
module bia_rf_mdl
(
    // Clock
    input wire clk_i,
    // Write-back from the unit
    input wire wr_i,
    input wire [31:0] res_i,
    // Destination register as the core sees it
    output reg [31:0] dst_reg_o
);
    // ----------------------------------------
    // Destination register
    // ----------------------------------------
    initial dst_reg_o = 32'h0;
    // Only a write strobe may touch it; compare must not
    always @(posedge clk_i)
    begin
        if (wr_i)
        begin
            dst_reg_o <= res_i;
        end
    end
endmodule // bia_rf_mdl

// ===== tb/bia_alu_asserts.sv
// Port checker for the arithmetic unit
`timescale 1ns/1ps
module bia_alu_chk
(
    // Clock and reset
    input wire clk_i,
    input wire rst_b_i,
    // Request
    input wire start_i,
    input wire [3:0] op_i,
    input wire [1:0] size_i,
    input wire src_mem_i,
    input wire dst_mem_i,
    // Results and flags
    input wire [31:0] result_o,
    input wire [31:0] result_hi_o,
    input wire write_o,
    input wire done_o,
    input wire illegal_o,
    input wire carry_flag_o,
    input wire parity_flag_o,
    input wire zero_flag_o,
    input wire sign_flag_o,
    input wire overflow_flag_o
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // Form 3 refusal left to the bench: form is not watched here
    wire bad = (src_mem_i && dst_mem_i) || op_i > 4'h9 || size_i == 2'h3;
    function automatic logic sbit(input logic [31:0] r, input logic [1:0] s);
        sbit = (s == 2'h0) ? r[7] : ((s == 2'h1) ? r[15] : r[31]);
    endfunction
    sequence s_req;
        start_i && rst_b_i;
    endsequence
    sequence s_ok(logic [3:0] lo, logic [3:0] hi);
        s_req ##0 (!bad && op_i >= lo && op_i <= hi);
    endsequence
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_done_one: assert property (s_req |=> done_o) else $error("done missing");
    a_done_idle: assert property (!start_i |=> !done_o && !write_o) else $error("done without start");
    a_refuse_mem: assert property (s_req ##0 (src_mem_i && dst_mem_i) |=> illegal_o && !write_o)
        else $error("memory pair taken");
    a_cmp_nowrite: assert property (s_ok(4'h6, 4'h6) |=> done_o && !write_o) else $error("compare wrote");
    a_inc_keep_cf: assert property (s_ok(4'h2, 4'h2) |=> carry_flag_o == $past(carry_flag_o))
        else $error("plus one moved carry");
    a_dec_keep_cf: assert property (s_ok(4'h5, 4'h5) |=> $stable(carry_flag_o)) else $error("minus one moved carry");
    a_zero_sized: assert property (s_ok(4'h0, 4'h5) |=> zero_flag_o == (result_o == 32'h0))
        else $error("zero flag wrong");
    a_sign_copy: assert property (s_ok(4'h0, 4'h5) |=> sign_flag_o == sbit(result_o, $past(size_i)))
        else $error("sign flag wrong");
    a_parity_low: assert property (s_ok(4'h0, 4'h5) |=> parity_flag_o == ~^result_o[7:0])
        else $error("parity flag wrong");
    a_mul_flags: assert property (s_ok(4'h8, 4'h8) |=> carry_flag_o == overflow_flag_o
        && carry_flag_o == (result_hi_o != 32'h0)) else $error("product flags wrong");
endmodule // bia_alu_chk
bind bia_alu bia_alu_chk u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .start_i(start_i), .op_i(op_i),
    .size_i(size_i), .src_mem_i(src_mem_i), .dst_mem_i(dst_mem_i), .result_o(result_o),
    .result_hi_o(result_hi_o), .write_o(write_o), .done_o(done_o), .illegal_o(illegal_o),
    .carry_flag_o(carry_flag_o), .parity_flag_o(parity_flag_o), .zero_flag_o(zero_flag_o),
    .sign_flag_o(sign_flag_o), .overflow_flag_o(overflow_flag_o));

// ===== tb/tb.sv
// Testbench for the arithmetic unit
`timescale 1ns/1ps
module tb;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic start_i = 1'b0;
    logic [3:0] op_i = 4'h0;
    logic [1:0] size_i = 2'h0;
    logic [1:0] form_i = 2'h0;
    logic src_mem_i = 1'b0;
    logic dst_mem_i = 1'b0;
    logic [31:0] dst_i = 32'h0;
    logic [31:0] src_i = 32'h0;
    logic [31:0] acc_i = 32'h0;
    logic [31:0] imm_i = 32'h0;
    logic imm_byte_i = 1'b0;
    logic flags_load_i = 1'b0;
    logic [5:0] flags_i = 6'h0;
    wire [31:0] result_o, result_hi_o, rf_q;
    wire write_o, write_hi_o, done_o, illegal_o;
    wire carry_flag_o, parity_flag_o, aux_carry_flag_o, zero_flag_o, sign_flag_o, overflow_flag_o;
    wire [5:0] fl = {overflow_flag_o, sign_flag_o, zero_flag_o, aux_carry_flag_o, parity_flag_o, carry_flag_o};
    wire [3:0] st = {done_o, write_o, write_hi_o, illegal_o};
    int errors = 0;
    int num_checks = 0;
    always #12.5 clk_i = ~clk_i;
    bia_alu uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .start_i(start_i), .op_i(op_i), .size_i(size_i),
        .form_i(form_i), .src_mem_i(src_mem_i), .dst_mem_i(dst_mem_i), .dst_i(dst_i), .src_i(src_i),
        .acc_i(acc_i), .imm_i(imm_i), .imm_byte_i(imm_byte_i), .flags_load_i(flags_load_i),
        .flags_i(flags_i), .result_o(result_o), .result_hi_o(result_hi_o), .write_o(write_o),
        .write_hi_o(write_hi_o), .done_o(done_o), .illegal_o(illegal_o), .carry_flag_o(carry_flag_o),
        .parity_flag_o(parity_flag_o), .aux_carry_flag_o(aux_carry_flag_o), .zero_flag_o(zero_flag_o),
        .sign_flag_o(sign_flag_o), .overflow_flag_o(overflow_flag_o));
    bia_rf_mdl mdl (.clk_i(clk_i), .wr_i(write_o), .res_i(result_o), .dst_reg_o(rf_q));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic stop_test;
        if (errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic ck(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // Inputs change at falling edge; outputs read at the next falling edge, one cycle later
    task automatic go(input logic [3:0] op, input logic [1:0] sz, input logic [1:0] fm,
        input logic [31:0] d, input logic [31:0] s, input logic [31:0] a);
        @(negedge clk_i);
        op_i = op;
        size_i = sz;
        form_i = fm;
        dst_i = d;
        src_i = s;
        acc_i = a;
        start_i = 1'b1;
        @(negedge clk_i);
        start_i = 1'b0;
    endtask
    task automatic ld(input logic [5:0] f);
        @(negedge clk_i);
        flags_i = f;
        flags_load_i = 1'b1;
        @(negedge clk_i);
        flags_load_i = 1'b0;
    endtask
    task automatic cr(input logic [31:0] r, input logic [5:0] f);
        ck(result_o, r);
        ck({26'h0, fl}, {26'h0, f});
    endtask
    task automatic cp(input logic [31:0] lo, input logic [31:0] hi, input logic c, input logic [3:0] s);
        ck(result_o, lo);
        ck(result_hi_o, hi);
        ck({30'h0, overflow_flag_o, carry_flag_o}, {30'h0, c, c});
        ck({28'h0, st}, {28'h0, s});
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_add;
        go(4'h0, 2'h0, 2'h0, 32'hff, 32'h01, 32'h0);
        cr(32'h0, 6'h0f);
        ck({28'h0, st}, 32'hc);
        go(4'h0, 2'h0, 2'h0, 32'h7f, 32'h01, 32'h0);
        cr(32'h80, 6'h34);
        go(4'h0, 2'h1, 2'h0, 32'hff, 32'h01, 32'h0);
        cr(32'h100, 6'h06);
    endtask
    task automatic t_adc;
        ld(6'h01);
        go(4'h1, 2'h1, 2'h0, 32'hffff, 32'h0, 32'h0);
        cr(32'h0, 6'h0f);
        go(4'h1, 2'h1, 2'h0, 32'h1, 32'h2, 32'h0);
        cr(32'h4, 6'h00);
        go(4'h1, 2'h1, 2'h0, 32'h1, 32'h2, 32'h0);
        cr(32'h3, 6'h02);
    endtask
    task automatic t_sub;
        go(4'h3, 2'h2, 2'h0, 32'h0, 32'h1, 32'h0);
        cr(32'hffffffff, 6'h17);
        go(4'h3, 2'h1, 2'h0, 32'h8000, 32'h1, 32'h0);
        cr(32'h7fff, 6'h26);
        ld(6'h01);
        go(4'h4, 2'h2, 2'h0, 32'h5, 32'h3, 32'h0);
        cr(32'h1, 6'h00);
        go(4'h4, 2'h0, 2'h0, 32'h0, 32'h0, 32'h0);
        cr(32'h0, 6'h0a);
    endtask
    task automatic t_incdec;
        ld(6'h01);
        go(4'h2, 2'h0, 2'h0, 32'hff, 32'h0, 32'h0);
        cr(32'h0, 6'h0f);
        ld(6'h00);
        go(4'h2, 2'h0, 2'h0, 32'h7f, 32'h0, 32'h0);
        cr(32'h80, 6'h34);
        go(4'h5, 2'h0, 2'h0, 32'h80, 32'h0, 32'h0);
        cr(32'h7f, 6'h24);
        ld(6'h01);
        go(4'h5, 2'h2, 2'h0, 32'h0, 32'h0, 32'h0);
        cr(32'hffffffff, 6'h17);
    endtask
    task automatic t_cmp_neg;
        go(4'h0, 2'h2, 2'h0, 32'h0, 32'h55, 32'h0);
        go(4'h6, 2'h1, 2'h0, 32'h3, 32'h5, 32'h0);
        ck({26'h0, fl}, 32'h15);
        ck({28'h0, st}, 32'h8);
        go(4'h6, 2'h2, 2'h0, 32'h7, 32'h7, 32'h0);
        ck({26'h0, fl}, 32'h0a);
        ck(rf_q, 32'h55);
        go(4'h7, 2'h0, 2'h0, 32'h01, 32'h0, 32'h0);
        cr(32'hff, 6'h17);
        go(4'h7, 2'h0, 2'h0, 32'h80, 32'h0, 32'h0);
        cr(32'h80, 6'h31);
        go(4'h7, 2'h0, 2'h0, 32'h0, 32'h0, 32'h0);
        cr(32'h0, 6'h0a);
    endtask
    task automatic t_mul;
        go(4'h8, 2'h1, 2'h0, 32'h0, 32'h100, 32'h1234);
        cp(32'h3400, 32'h12, 1'b1, 4'he);
        go(4'h8, 2'h0, 2'h0, 32'h0, 32'h10, 32'h0f);
        cp(32'hf0, 32'h0, 1'b0, 4'he);
        go(4'h8, 2'h2, 2'h0, 32'h0, 32'h2, 32'hffffffff);
        cp(32'hfffffffe, 32'h1, 1'b1, 4'he);
    endtask
    task automatic t_signed_product_op;
        go(4'h9, 2'h0, 2'h0, 32'h0, 32'h02, 32'hff);
        cp(32'hfe, 32'hff, 1'b0, 4'he);
        go(4'h9, 2'h0, 2'h0, 32'h0, 32'h04, 32'h40);
        cp(32'h0, 32'h1, 1'b1, 4'he);
        go(4'h9, 2'h2, 2'h1, 32'h10000, 32'h10000, 32'h0);
        cp(32'h0, 32'h1, 1'b1, 4'hc);
        go(4'h9, 2'h1, 2'h1, 32'hffff, 32'hffff, 32'h0);
        ck(result_o, 32'h1);
        imm_i = 32'h123456fe;
        imm_byte_i = 1'b1;
        go(4'h9, 2'h1, 2'h2, 32'h0, 32'h3, 32'h0);
        cp(32'hfffa, 32'hffff, 1'b0, 4'hc);
        imm_byte_i = 1'b0;
    endtask
    // Refused requests must leave the flags exactly as loaded
    task automatic t_refuse;
        src_mem_i = 1'b1;
        go(4'h0, 2'h0, 2'h0, 32'h1, 32'h1, 32'h0);
        ck({28'h0, st}, 32'hc);
        ld(6'h15);
        dst_mem_i = 1'b1;
        go(4'h0, 2'h0, 2'h0, 32'h1, 32'h1, 32'h0);
        ck({28'h0, st}, 32'h9);
        src_mem_i = 1'b0;
        dst_mem_i = 1'b0;
        go(4'h0, 2'h3, 2'h0, 32'h1, 32'h1, 32'h0);
        ck({28'h0, st}, 32'h9);
        go(4'ha, 2'h0, 2'h0, 32'h1, 32'h1, 32'h0);
        ck({28'h0, st}, 32'h9);
        go(4'h9, 2'h0, 2'h3, 32'h1, 32'h1, 32'h1);
        ck({28'h0, st}, 32'h9);
        ck({26'h0, fl}, 32'h15);
    endtask
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        rst_b_i = 1'b1;
        t_add();
        t_adc();
        t_sub();
        t_incdec();
        t_cmp_neg();
        t_mul();
        t_signed_product_op();
        t_refuse();
        stop_test();
    end
    // About 80 cycles expected; 1500, near nineteen times that, is a hang
    initial
    begin
        repeat (1500) @(posedge clk_i);
        errors++;
        stop_test();
    end
endmodule // tb
